// file: cce_pkg.sv
package cce_pkg;
    // Four clock phases make one instruction cycle
    localparam int PHASES_PER_CYCLE = 4;
    typedef enum logic [3:0] {
        CCE_Q1 = 4'h1,
        CCE_Q2 = 4'h2,
        CCE_Q3 = 4'h4,
        CCE_Q4 = 4'h8
    } cce_phase_t;

    // Normal execution, or the idle second cycle of a call
    typedef enum logic [1:0] {
        CCE_ST_NORMAL = 2'h1,
        CCE_ST_CALL2 = 2'h2
    } cce_state_t;

    // Instruction encodings
    localparam logic [15:0] CLEAR_WATCHDOG_WORD = 16'h0004;
    localparam logic [15:0] NOP_WORD = 16'h0000;
    localparam logic [6:0] CLEAR_FILE_OPC = 7'h35;
    localparam logic [6:0] CALL_OPC = 7'h76;
    localparam int OPC_MSB = 15;
    localparam int OPC_LSB = 9;
    localparam int BANK_ACCESS_BIT = 8;
    localparam int SHADOW_SEL_BIT = 8;
    localparam int FILE_MSB = 7;

    // Widths, values and reset states
    localparam int PC_W = 21;
    localparam int BANK_W = 4;
    localparam int DATA_W = 8;
    localparam int LIT_HI_W = 12;
    localparam logic [BANK_W-1:0] ACCESS_BANK = 4'h0;
    localparam logic [DATA_W-1:0] CLEAR_DATA = 8'h00;
    localparam logic [PC_W-1:0] RETURN_STEP = 21'h000004;
    localparam logic TIMEOUT_RESET = 1'h1;
    localparam logic POWERDOWN_RESET = 1'h1;
    localparam logic STATUS_SET = 1'h1;
endpackage

// file: cce_exec.sv
`timescale 1ns/1ns
// Overview of operation
// - Clear-watchdog word 0x0004 clears the watchdog counter in one cycle.
// - Clear-watchdog also clears the watchdog postscaler.
// - Clear-watchdog sets timeout and powerdown status bits, no arithmetic flags.
// - Clear-file writes zero to the addressed location and sets zero flag.
// - Bank-access bit zero selects the shared low bank, ignoring bank select.
// - Bank-access bit one takes the bank from the bank select register.
// - Call pushes PC plus four, loads 20-bit literal into PC 20:1.
// - Call with shadow bit set copies W, status, bank select to shadows.
module cce_exec (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic [15:0] i_instr,
    input wire logic [cce_pkg::PC_W-1:0] i_pc,
    input wire logic [cce_pkg::DATA_W-1:0] i_working,
    input wire logic [cce_pkg::DATA_W-1:0] i_status,
    input wire logic [cce_pkg::BANK_W-1:0] i_bank_select,
    input wire logic i_timeout_event,
    input wire logic i_sleep_event,
    output logic [3:0] o_phase,
    output logic o_dmem_we,
    output logic [cce_pkg::BANK_W+cce_pkg::DATA_W-1:0] o_dmem_addr,
    output logic [cce_pkg::DATA_W-1:0] o_dmem_wdata,
    output logic o_zero_set,
    output logic o_watchdog_counter_clr,
    output logic o_watchdog_postscaler_clr,
    output logic o_timeout_status_bit,
    output logic o_powerdown_status_bit,
    output logic o_stack_push,
    output logic [cce_pkg::PC_W-1:0] o_return_stack_top,
    output logic o_pc_load,
    output logic [cce_pkg::PC_W-1:0] o_pc_value,
    output logic [cce_pkg::DATA_W-1:0] o_working_shadow,
    output logic [cce_pkg::DATA_W-1:0] o_status_shadow,
    output logic [cce_pkg::BANK_W-1:0] o_bank_select_shadow
);
    localparam int AW = cce_pkg::BANK_W + cce_pkg::DATA_W;

    cce_pkg::cce_phase_t phase_q;
    cce_pkg::cce_phase_t phase_d;
    cce_pkg::cce_state_t state_q;
    cce_pkg::cce_state_t state_d;
    logic [15:0] instr_q;
    logic [15:0] instr_d;
    logic [AW-1:0] addr_q;
    logic we_q;
    logic zero_q;
    logic wd_clear_q;
    logic tmo_q;
    logic pwrdn_q;
    logic push_q;
    logic [cce_pkg::PC_W-1:0] ret_top_q;
    logic pc_load_q;
    logic [cce_pkg::PC_W-1:0] pc_val_q;
    logic [cce_pkg::DATA_W-1:0] wshadow_q;
    logic [cce_pkg::DATA_W-1:0] ss_q;
    logic [cce_pkg::BANK_W-1:0] bs_q;

    // Phase decode
    wire in_q1 = (phase_q == cce_pkg::CCE_Q1);
    wire in_q2 = (phase_q == cce_pkg::CCE_Q2);
    wire in_q3 = (phase_q == cce_pkg::CCE_Q3);
    wire in_q4 = (phase_q == cce_pkg::CCE_Q4);

    // Instruction decode from the latched word
    wire [6:0] opc = instr_q[cce_pkg::OPC_MSB:cce_pkg::OPC_LSB];
    wire is_clear_wd = (instr_q == cce_pkg::CLEAR_WATCHDOG_WORD);
    wire is_clear_file = (opc == cce_pkg::CLEAR_FILE_OPC);
    wire is_call = (opc == cce_pkg::CALL_OPC);
    wire bank_bit = instr_q[cce_pkg::BANK_ACCESS_BIT];
    wire shadow_bit = instr_q[cce_pkg::SHADOW_SEL_BIT];
    wire [cce_pkg::DATA_W-1:0] file_f = instr_q[cce_pkg::FILE_MSB:0];

    // Bank choice: shared low bank overrides bank select when bit is low
    wire [cce_pkg::BANK_W-1:0] bank_sel =
        bank_bit ? i_bank_select : cce_pkg::ACCESS_BANK;
    wire [AW-1:0] addr_d =
        in_q2 && is_clear_file ? {bank_sel, file_f} : addr_q;

    // Return address and call target
    wire [cce_pkg::PC_W-1:0] ret_addr = i_pc + cce_pkg::RETURN_STEP;
    wire [cce_pkg::PC_W-1:0] call_target =
        {i_instr[cce_pkg::LIT_HI_W-1:0], instr_q[7:0], 1'b0};
    wire call_push_d = in_q2 && is_call;
    wire shadow_cp = call_push_d && shadow_bit;

    // Clear-watchdog status bits; the instruction beats a same-cycle clear
    wire tmo_d = wd_clear_q ? cce_pkg::STATUS_SET :
        (i_timeout_event ? 1'b0 : tmo_q);
    wire pwrdn_d = wd_clear_q ? cce_pkg::STATUS_SET :
        (i_sleep_event ? 1'b0 : pwrdn_q);

    // Phase rotation, decode latch in Q1; second call word is never decoded
    always_comb begin
        unique case (phase_q)
            cce_pkg::CCE_Q1: phase_d = cce_pkg::CCE_Q2;
            cce_pkg::CCE_Q2: phase_d = cce_pkg::CCE_Q3;
            cce_pkg::CCE_Q3: phase_d = cce_pkg::CCE_Q4;
            cce_pkg::CCE_Q4: phase_d = cce_pkg::CCE_Q1;
            default: phase_d = cce_pkg::CCE_Q1;
        endcase
        instr_d = instr_q;
        if (in_q1) begin
            instr_d = (state_q == cce_pkg::CCE_ST_CALL2) ?
                cce_pkg::NOP_WORD : i_instr;
        end
        state_d = state_q;
        if (in_q4) begin
            unique case (state_q)
                cce_pkg::CCE_ST_NORMAL: state_d = is_call ?
                    cce_pkg::CCE_ST_CALL2 : cce_pkg::CCE_ST_NORMAL;
                cce_pkg::CCE_ST_CALL2: state_d = cce_pkg::CCE_ST_NORMAL;
                default: state_d = cce_pkg::CCE_ST_NORMAL;
            endcase
        end
    end

    // Sequencer state
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            phase_q <= cce_pkg::CCE_Q1;
            state_q <= cce_pkg::CCE_ST_NORMAL;
            instr_q <= cce_pkg::NOP_WORD;
        end else begin
            phase_q <= phase_d;
            state_q <= state_d;
            instr_q <= instr_d;
        end
    end

    // Clear-file: address in Q3, write strobe and zero flag in Q4
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            addr_q <= '0;
            we_q <= 1'b0;
            zero_q <= 1'b0;
        end else begin
            addr_q <= addr_d;
            we_q <= in_q3 && is_clear_file;
            zero_q <= in_q3 && is_clear_file;
        end
    end

    // Clear-watchdog: one pulse in Q3 clears counter and postscaler
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wd_clear_q <= 1'b0;
            tmo_q <= cce_pkg::TIMEOUT_RESET;
            pwrdn_q <= cce_pkg::POWERDOWN_RESET;
        end else begin
            wd_clear_q <= in_q2 && is_clear_wd;
            tmo_q <= tmo_d;
            pwrdn_q <= pwrdn_d;
        end
    end

    // Call: push in Q3, PC load in Q4 from the second word
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            push_q <= 1'b0;
            ret_top_q <= '0;
            pc_load_q <= 1'b0;
            pc_val_q <= '0;
        end else begin
            push_q <= call_push_d;
            if (call_push_d) begin
                ret_top_q <= ret_addr;
            end
            pc_load_q <= in_q3 && is_call;
            if (in_q3 && is_call) begin
                pc_val_q <= call_target;
            end
        end
    end

    // Shadow copies only move when the shadow bit asks for it
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wshadow_q <= '0;
            ss_q <= '0;
            bs_q <= '0;
        end else if (shadow_cp) begin
            wshadow_q <= i_working;
            ss_q <= i_status;
            bs_q <= i_bank_select;
        end
    end

    // Outputs straight from flops, except o_dmem_wdata which is the constant CLEAR_DATA
    assign o_phase = phase_q;
    assign o_dmem_we = we_q;
    assign o_dmem_addr = addr_q;
    assign o_dmem_wdata = cce_pkg::CLEAR_DATA;
    assign o_zero_set = zero_q;
    assign o_watchdog_counter_clr = wd_clear_q;
    assign o_watchdog_postscaler_clr = wd_clear_q;
    assign o_timeout_status_bit = tmo_q;
    assign o_powerdown_status_bit = pwrdn_q;
    assign o_stack_push = push_q;
    assign o_return_stack_top = ret_top_q;
    assign o_pc_load = pc_load_q;
    assign o_pc_value = pc_val_q;
    assign o_working_shadow = wshadow_q;
    assign o_status_shadow = ss_q;
    assign o_bank_select_shadow = bs_q;

    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    wire fetch = in_q1 && (state_q == cce_pkg::CCE_ST_NORMAL);
    wire skipped = in_q1 && (state_q == cce_pkg::CCE_ST_CALL2);
    wire [6:0] in_opc = i_instr[cce_pkg::OPC_MSB:cce_pkg::OPC_LSB];
    wire f_clear_wd = fetch && (i_instr == cce_pkg::CLEAR_WATCHDOG_WORD);
    wire f_clear_file = fetch && (in_opc == cce_pkg::CLEAR_FILE_OPC);
    wire f_call = fetch && (in_opc == cce_pkg::CALL_OPC);

    sequence phase_ring_s;
        in_q2 ##1 in_q3 ##1 in_q4 ##1 in_q1;
    endsequence
    sequence call_tail_s;
        o_pc_load ##1 (!o_pc_load && !o_stack_push) [*4];
    endsequence

    phase_order_a: assert property (in_q1 |=> phase_ring_s)
        else $error("phase order broken");
    watchdog_clear_a: assert property (f_clear_wd |->
        ##2 o_watchdog_counter_clr ##1 !o_watchdog_counter_clr)
        else $error("watchdog clear missing");
    postscaler_clear_a: assert property (f_clear_wd |->
        ##2 o_watchdog_postscaler_clr ##1 !o_watchdog_postscaler_clr)
        else $error("postscaler clear missing");
    status_set_a: assert property (o_watchdog_counter_clr |=>
        o_timeout_status_bit && o_powerdown_status_bit && !o_zero_set)
        else $error("status bits not set");
    file_clear_a: assert property (f_clear_file |-> ##3
        o_dmem_we && o_zero_set && o_dmem_wdata == cce_pkg::CLEAR_DATA)
        else $error("clear-file write missing");
    access_bank_a: assert property (f_clear_file && !i_instr[8] |->
        ##3 o_dmem_addr == {cce_pkg::ACCESS_BANK, $past(i_instr[7:0], 3)})
        else $error("access bank address wrong");
    banked_addr_a: assert property (f_clear_file && i_instr[8] |->
        ##3 o_dmem_addr ==
        {$past(i_bank_select, 2), $past(i_instr[7:0], 3)})
        else $error("banked address wrong");
    call_push_a: assert property (f_call |-> ##2 o_stack_push &&
        o_return_stack_top == $past(i_pc) + cce_pkg::RETURN_STEP
        ##1 call_tail_s)
        else $error("call push or load wrong");
    // A word offered in the second call cycle must start nothing
    call_skip_a: assert property (skipped |-> ##2
        (!o_watchdog_counter_clr && !o_stack_push) ##1 !o_dmem_we)
        else $error("word decoded in second call cycle");
    shadow_keep_a: assert property (f_call && !i_instr[8] |-> ##2
        $stable(o_working_shadow) && $stable(o_status_shadow) &&
        $stable(o_bank_select_shadow))
        else $error("shadow changed without request");
    shadow_copy_a: assert property (f_call && i_instr[8] |-> ##2
        o_working_shadow == $past(i_working) &&
        o_status_shadow == $past(i_status) &&
        o_bank_select_shadow == $past(i_bank_select))
        else $error("shadow copy wrong");
endmodule

// file: cce_exec_tb.sv
`timescale 1ns/1ns
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_count++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, a, e); end end
module cce_exec_tb;
    logic i_clk, i_reset_n, i_timeout_event, i_sleep_event;
    logic [15:0] i_instr;
    logic [20:0] i_pc;
    logic [7:0] i_working, i_status, o_dmem_wdata, o_working_shadow;
    logic [7:0] o_status_shadow;
    logic [3:0] i_bank_select, o_phase, o_bank_select_shadow;
    logic o_dmem_we, o_zero_set, o_watchdog_counter_clr, o_stack_push;
    logic o_watchdog_postscaler_clr, o_timeout_status_bit, o_pc_load;
    logic o_powerdown_status_bit;
    logic [11:0] o_dmem_addr, q3_addr;
    logic [20:0] o_return_stack_top, o_pc_value;
    logic q3_clr, q3_post, q3_push, q3_tmo, q4_clr, q4_tmo, q4_pwr;
    logic q4_we, q4_zero, q4_load, q3_event;
    int err_count = 0;
    int cmp_count = 0;

    cce_exec uut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_instr(i_instr),
        .i_pc(i_pc), .i_working(i_working), .i_status(i_status),
        .i_bank_select(i_bank_select), .i_timeout_event(i_timeout_event),
        .i_sleep_event(i_sleep_event), .o_phase(o_phase),
        .o_dmem_we(o_dmem_we), .o_dmem_addr(o_dmem_addr),
        .o_dmem_wdata(o_dmem_wdata), .o_zero_set(o_zero_set),
        .o_watchdog_counter_clr(o_watchdog_counter_clr),
        .o_watchdog_postscaler_clr(o_watchdog_postscaler_clr),
        .o_timeout_status_bit(o_timeout_status_bit),
        .o_powerdown_status_bit(o_powerdown_status_bit),
        .o_stack_push(o_stack_push), .o_return_stack_top(o_return_stack_top),
        .o_pc_load(o_pc_load), .o_pc_value(o_pc_value),
        .o_working_shadow(o_working_shadow),
        .o_status_shadow(o_status_shadow),
        .o_bank_select_shadow(o_bank_select_shadow));

    // 125 MHz clock
    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end

    task automatic final_report();
        $display("Compared %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Issue one instruction cycle; second word goes out in Q3 for a call
    task automatic run(input logic [15:0] w1, input logic [15:0] w2);
        int n;
        n = 0;
        while (o_phase !== 4'h1 && n < 20) begin
            @(negedge i_clk);
            n++;
        end
        `CHK(o_phase, 4'h1)
        i_instr = w1;
        @(negedge i_clk);
        `CHK(o_phase, 4'h2)
        i_instr = cce_pkg::NOP_WORD;
        @(negedge i_clk);
        `CHK(o_phase, 4'h4)
        q3_clr = o_watchdog_counter_clr;
        q3_post = o_watchdog_postscaler_clr;
        q3_push = o_stack_push;
        q3_addr = o_dmem_addr;
        q3_tmo = o_timeout_status_bit;
        i_instr = w2;
        // Optional events across the edge that sets the status bits
        i_timeout_event = q3_event;
        i_sleep_event = q3_event;
        @(negedge i_clk);
        `CHK(o_phase, 4'h8)
        q4_clr = o_watchdog_counter_clr;
        q4_tmo = o_timeout_status_bit;
        q4_pwr = o_powerdown_status_bit;
        q4_we = o_dmem_we;
        q4_zero = o_zero_set;
        q4_load = o_pc_load;
        i_instr = cce_pkg::NOP_WORD;
        i_timeout_event = 1'b0;
        i_sleep_event = 1'b0;
    endtask

    // Second call cycle: a word offered in its Q1 must do nothing
    task automatic call_tail();
        i_instr = cce_pkg::CLEAR_WATCHDOG_WORD;
        // Word stays up across the Q1 edge, dropped in Q2
        for (int k = 0; k < 4; k++) begin
            @(negedge i_clk);
            if (k == 1) begin
                i_instr = cce_pkg::NOP_WORD;
            end
            `CHK(o_watchdog_counter_clr | o_stack_push | o_pc_load, 1'b0)
        end
    endtask

    // Clear-file with access bit a, bank select b, file address f
    task automatic clear_file(input logic a, input logic [3:0] b,
                              input logic [7:0] f);
        i_bank_select = b;
        run({cce_pkg::CLEAR_FILE_OPC, a, f}, cce_pkg::NOP_WORD);
        `CHK(q3_addr, {(a ? b : cce_pkg::ACCESS_BANK), f})
        `CHK({q4_we, q4_zero, q3_clr}, 3'b110)
        `CHK(o_dmem_wdata, 8'h00)
    endtask

    initial begin
        i_reset_n = 1'b0;
        i_instr = cce_pkg::NOP_WORD;
        i_pc = 21'h000000;
        i_working = 8'h00;
        i_status = 8'h00;
        i_bank_select = 4'h0;
        i_timeout_event = 1'b0;
        i_sleep_event = 1'b0;
        q3_event = 1'b0;
        repeat (6) @(negedge i_clk);
        `CHK({o_timeout_status_bit, o_powerdown_status_bit}, 2'b11)
        i_reset_n = 1'b1;
        // Drop both status bits, then clear-watchdog must raise them
        i_timeout_event = 1'b1;
        i_sleep_event = 1'b1;
        @(negedge i_clk);
        i_timeout_event = 1'b0;
        i_sleep_event = 1'b0;
        @(negedge i_clk);
        `CHK({o_timeout_status_bit, o_powerdown_status_bit}, 2'b00)
        run(cce_pkg::CLEAR_WATCHDOG_WORD, cce_pkg::NOP_WORD);
        `CHK({q3_clr, q4_clr}, 2'b10)
        `CHK(q3_post, 1'b1)
        `CHK({q3_tmo, q4_tmo, q4_pwr}, 3'b011)
        `CHK({q4_zero, q4_we}, 2'b00)
        // Same-cycle timeout and sleep events lose to the set
        q3_event = 1'b1;
        run(cce_pkg::CLEAR_WATCHDOG_WORD, cce_pkg::NOP_WORD);
        q3_event = 1'b0;
        `CHK({q3_clr, q4_tmo, q4_pwr}, 3'b111)
        // Both bank modes, bank select value must be ignored for a=0
        clear_file(1'b0, 4'hA, 8'hFF);
        clear_file(1'b1, 4'hA, 8'h5C);
        clear_file(1'b1, 4'hF, 8'h00);
        // Call without shadow copy
        i_pc = 21'h1FFFF8;
        i_working = 8'hA5;
        i_status = 8'h3C;
        i_bank_select = 4'h7;
        run(16'hEC34, 16'hF123);
        `CHK({q3_push, q4_load}, 2'b11)
        `CHK(o_return_stack_top, 21'h1FFFFC)
        `CHK(o_pc_value, 21'h024668)
        `CHK({o_working_shadow, o_status_shadow}, 16'h0000)
        `CHK(o_bank_select_shadow, 4'h0)
        call_tail();
        // Call with shadow copy, all literal bits set
        i_pc = 21'h000100;
        run(16'hEDFF, 16'hFFFF);
        `CHK(o_return_stack_top, 21'h000104)
        `CHK(o_pc_value, 21'h1FFFFE)
        `CHK({o_working_shadow, o_status_shadow}, 16'hA53C)
        `CHK(o_bank_select_shadow, 4'h7)
        call_tail();
        clear_file(1'b0, 4'h3, 8'h01);
        final_report();
    end

    // Whole run needs well under 200 cycles
    initial begin
        #16000;
        err_count++;
        final_report();
    end
endmodule
